/* File: core/prot_seq_pkg.sv */
// constants for the pwm protection and gating sequencer
// assumes a 40 mhz system clock; counts derive from printed times except sample delay and startup blanking
package prot_seq_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int BROWN_IN_QUALIFY_TIME_US = 100;
   localparam int BROWN_OUT_QUALIFY_TIME_MS = 50;
   localparam int CTRL_LOW_TIME_MS = 32;
   localparam int CS_SAMPLE_DELAY_US = 4;
   localparam int LEB_TIME_NS = 250;
   localparam int CTRL_LEAD_TIME_NS = 100;
   localparam int FAULT_CYCLES = 7;
   // least times round up to whole cycles
   localparam int BROWN_IN_CYC = (BROWN_IN_QUALIFY_TIME_US * (CLK_HZ / 1000000));
   localparam int BROWN_OUT_CYC = (BROWN_OUT_QUALIFY_TIME_MS * (CLK_HZ / 1000));
   localparam int CTRL_LOW_CYC = (CTRL_LOW_TIME_MS * (CLK_HZ / 1000));
   localparam int CS_SAMPLE_CYC = (CS_SAMPLE_DELAY_US * (CLK_HZ / 1000000));
   localparam int LEB_CYC = ((LEB_TIME_NS * (CLK_HZ / 1000000)) + 999) / 1000;
   localparam int CTRL_LEAD_CYC = ((CTRL_LEAD_TIME_NS * (CLK_HZ / 1000000)) + 999) / 1000;
   localparam int SAMPLE_DELAY_CYC = 40;
   localparam int STARTUP_UNDERVOLT_BLANK_CYC = 400000;
   typedef enum logic [3:0] {
      ST_WAIT = 4'h1,
      ST_RUN = 4'h2,
      ST_BROWN = 4'h4,
      ST_FAULT = 4'h8
   } seq_state_t;
endpackage

/* File: core/cycle_debounce.sv */
// consecutive-cycle fault counter; one strobe per switching cycle
// assumes strobe and level are on clk_i
`timescale 1ns/1ps
`default_nettype none
module cycle_debounce #(
   parameter int COUNT = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic strobe_i,
   input wire logic level_i,
   output logic trip_o
);
   logic [3:0] cnt;
   wire [3:0] next_cnt = level_i ? ((cnt == 4'(COUNT)) ? cnt : cnt + 4'h1) : 4'h0;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
      end else if (strobe_i) begin
         cnt <= next_cnt;
      end
   end
   assign trip_o = (cnt == 4'(COUNT));
endmodule
`default_nettype wire

/* File: core/pwm_fault_protection_sequencer.sv */
// protection and gating sequencer of an offline current-mode pwm controller
// assumes comparator inputs are asynchronous and rst_i is supply undervoltage lockout
// Functional notes
// - gate enables after line above brown-in 100us and supply at start threshold
// - line below brown-out 50ms turns gate off until brown-in requalifies
// - output sense sampled after gate fall; 7 cycles over/under trips shutdown
// - output under-voltage ignored during startup blanking interval
// - external pin sampled after gate fall; 7 cycles above high trips fault
// - external pin source current on only while the switch is on
// - low-side external pin sampled in the last clock before gate fall
// - external pin below low threshold continuously 32ms trips fault
// - any fault stops gate and latches until undervoltage lockout
// - line over-voltage for 7 switching cycles trips shutdown
// - current sense at fast threshold for 7 cycles trips shutdown
// - current sense sampled 4us after rise; low 7 cycles trips shutdown
// - internal over-temperature with hysteresis stops drive independently
// - no pwm pulses while feedback level below 1.2v
// - supply at maintain threshold enables high charging current
// - 250ns after turn-on comparators masked and turn-off blocked
// - after fault, high charging off until lockout; charge_fault_o tied low
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_protection_sequencer
   import prot_seq_pkg::*;
#(
   parameter int BROWN_OUT_COUNT = BROWN_OUT_CYC,
   parameter int CTRL_LOW_COUNT = CTRL_LOW_CYC,
   parameter int UV_BLANK_COUNT = STARTUP_UNDERVOLT_BLANK_CYC,
   parameter int SAMPLE_DELAY = SAMPLE_DELAY_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pwm_on_i,
   input wire logic pwm_off_i,
   input wire logic line_brown_in_i,
   input wire logic line_brown_out_i,
   input wire logic line_ovp_i,
   input wire logic supply_start_i,
   input wire logic supply_maintain_i,
   input wire logic out_ovp_i,
   input wire logic out_uvp_i,
   input wire logic ctrl_high_i,
   input wire logic ctrl_low_i,
   input wire logic cs_fast_oc_i,
   input wire logic cs_short_i,
   input wire logic otp_trip_i,
   input wire logic otp_release_i,
   input wire logic feedback_low_i,
   output logic gate_o,
   output logic ctrl_source_o,
   output logic charge_high_o,
   output logic charge_fault_o,
   output logic cmp_mask_o,
   output logic fault_o,
   output logic [6:0] fault_cause_o
);
   // two-flop synchronisers for every analog comparator
   localparam int NSYNC = 16;
   wire [NSYNC-1:0] raw = {pwm_on_i, pwm_off_i, line_brown_in_i, line_brown_out_i,
      line_ovp_i, supply_start_i, supply_maintain_i, out_ovp_i, out_uvp_i, ctrl_high_i,
      ctrl_low_i, cs_fast_oc_i, cs_short_i, otp_trip_i, otp_release_i, feedback_low_i};
   logic [NSYNC-1:0] meta;
   logic [NSYNC-1:0] sync;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= raw;
         sync <= meta;
      end
   end
   wire s_on = sync[15];
   wire s_off = sync[14];
   wire s_bin = sync[13];
   wire s_bout = sync[12];
   wire s_line_ov = sync[11];
   wire s_start = sync[10];
   wire s_maint = sync[9];
   wire s_oovp = sync[8];
   wire s_ouvp = sync[7];
   wire s_ch = sync[6];
   wire s_cl = sync[5];
   wire s_fast_oc = sync[4];
   wire s_short = sync[3];
   wire s_otp = sync[2];
   wire s_otp_rel = sync[1];
   wire s_fbl = sync[0];

   seq_state_t state;
   seq_state_t next_state;
   logic [21:0] line_cnt;
   logic [21:0] ctrl_low_cnt;
   logic [18:0] blank_cnt;
   logic [7:0] on_cnt;
   logic [7:0] off_cnt;
   logic [7:0] leb_cnt;
   logic ot_hot;
   logic [6:0] cause;

   wire running = (state == ST_RUN);
   wire leb_active = gate_o && (leb_cnt != 8'(LEB_CYC));
   wire brown_in_ok = s_bin && (line_cnt >= 22'(BROWN_IN_CYC));
   wire brown_out_hit = s_bout && (line_cnt >= 22'(BROWN_OUT_COUNT));
   wire next_gate = running && !ot_hot && !s_fbl && (s_on || gate_o) &&
      !(s_off && !leb_active);
   wire gate_rise = next_gate && !gate_o;
   wire gate_fall = gate_o && !next_gate;

   // cycle strobes derived from the gate edges
   wire fall_strobe = !gate_o && (off_cnt == 8'(SAMPLE_DELAY));
   wire cs_strobe = gate_o && (on_cnt == 8'(CS_SAMPLE_CYC));
   wire ctrl_lo_sample = gate_o && s_off && !leb_active;
   wire cycle_strobe = gate_rise;

   wire trip_ovp;
   wire trip_uvp;
   wire trip_ch;
   wire trip_line_ov;
   wire trip_fast_oc;
   wire trip_short;
   wire blanking = (blank_cnt != 19'(UV_BLANK_COUNT));
   cycle_debounce #(.COUNT(FAULT_CYCLES)) u_ovp (.clk_i(clk_i), .rst_i(rst_i),
      .strobe_i(fall_strobe), .level_i(s_oovp), .trip_o(trip_ovp));
   cycle_debounce #(.COUNT(FAULT_CYCLES)) u_uvp (.clk_i(clk_i), .rst_i(rst_i),
      .strobe_i(fall_strobe), .level_i(s_ouvp && !blanking), .trip_o(trip_uvp));
   cycle_debounce #(.COUNT(FAULT_CYCLES)) u_ch (.clk_i(clk_i), .rst_i(rst_i),
      .strobe_i(fall_strobe), .level_i(s_ch), .trip_o(trip_ch));
   cycle_debounce #(.COUNT(FAULT_CYCLES)) u_line_ov (.clk_i(clk_i), .rst_i(rst_i),
      .strobe_i(cycle_strobe), .level_i(s_line_ov), .trip_o(trip_line_ov));
   cycle_debounce #(.COUNT(FAULT_CYCLES)) u_fast_oc (.clk_i(clk_i), .rst_i(rst_i),
      .strobe_i(cycle_strobe), .level_i(s_fast_oc && !leb_active), .trip_o(trip_fast_oc));
   cycle_debounce #(.COUNT(FAULT_CYCLES)) u_scp (.clk_i(clk_i), .rst_i(rst_i),
      .strobe_i(cs_strobe), .level_i(s_short), .trip_o(trip_short));

   logic ctrl_low_state;
   wire trip_cl = (ctrl_low_cnt >= 22'(CTRL_LOW_COUNT));
   wire [6:0] trips = {trip_ovp, trip_uvp, trip_ch, trip_cl, trip_line_ov, trip_fast_oc,
      trip_short};
   wire any_trip = |trips;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_WAIT: if (brown_in_ok && s_start) next_state = ST_RUN;
         ST_RUN: begin
            if (any_trip) next_state = ST_FAULT;
            else if (brown_out_hit) next_state = ST_BROWN;
         end
         ST_BROWN: if (brown_in_ok) next_state = ST_RUN;
         ST_FAULT: next_state = ST_FAULT;
         default: next_state = ST_FAULT;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_WAIT;
         gate_o <= 1'b0;
         cause <= 7'h00;
      end else begin
         state <= next_state;
         gate_o <= next_gate && (next_state == ST_RUN);
         if (running) cause <= cause | trips;
      end
   end

   // line qualify timer restarts whenever the comparator of interest changes
   wire line_track = (state == ST_RUN) ? s_bout : s_bin;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_cnt <= 22'h0;
      end else if (!line_track) begin
         line_cnt <= 22'h0;
      end else if (line_cnt != 22'h3fffff) begin
         line_cnt <= line_cnt + 22'h1;
      end
   end

   // edge timers for sampling and leading-edge blanking
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         on_cnt <= 8'h00;
         off_cnt <= 8'hff;
         leb_cnt <= 8'h00;
      end else begin
         on_cnt <= gate_rise ? 8'h00 : (on_cnt != 8'hff ? on_cnt + 8'h1 : on_cnt);
         off_cnt <= gate_fall ? 8'h00 : (off_cnt != 8'hff ? off_cnt + 8'h1 : off_cnt);
         leb_cnt <= gate_rise ? 8'h00 : (leb_active ? leb_cnt + 8'h1 : leb_cnt);
      end
   end

   // low-side external level held from the pre-fall sample
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_low_state <= 1'b0;
         ctrl_low_cnt <= 22'h0;
      end else begin
         if (ctrl_lo_sample) ctrl_low_state <= s_cl;
         if (!ctrl_low_state || !running) ctrl_low_cnt <= 22'h0;
         else if (!trip_cl) ctrl_low_cnt <= ctrl_low_cnt + 22'h1;
      end
   end

   // startup blanking and thermal hysteresis
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         blank_cnt <= 19'h0;
         ot_hot <= 1'b0;
      end else begin
         if (running && blanking) blank_cnt <= blank_cnt + 19'h1;
         if (s_otp) ot_hot <= 1'b1;
         else if (s_otp_rel) ot_hot <= 1'b0;
      end
   end

   assign ctrl_source_o = gate_o;
   assign cmp_mask_o = leb_active;
   assign charge_high_o = (state != ST_FAULT) && (!s_start || (running && s_maint));
   assign charge_fault_o = 1'b0;
   assign fault_o = (state == ST_FAULT);
   assign fault_cause_o = cause;

   gate_latched_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_FAULT) |-> ##1 !gate_o) else $error("gate active in fault");
   fault_stays_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_o |=> fault_o) else $error("fault latch released");
   leb_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(gate_o) && state == ST_RUN && !ot_hot && !s_fbl && !any_trip && !brown_out_hit
      |=> gate_o)
      else $error("gate fell inside blanking");
   fb_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_fbl |=> !gate_o) else $error("pulse while feedback low");
   source_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_source_o == gate_o) else $error("source current mismatch");
   start_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(state) == ST_WAIT && state == ST_RUN |-> $past(s_start))
      else $error("run without start threshold");
   ovp_trip_a: assert property (@(posedge clk_i) disable iff (rst_i)
      running && trip_ovp |=> fault_o) else $error("ovp not latched");
   hot_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ot_hot |=> !gate_o) else $error("gate while hot");
   run_c: cover property (@(posedge clk_i) disable iff (rst_i) running && gate_o);
   fault_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fault_o));
   brown_c: cover property (@(posedge clk_i) disable iff (rst_i) state == ST_BROWN);
endmodule
`default_nettype wire

/* File: test/switch_model.sv */
// far-side switch timing: complementary turn-on and turn-off requests
// assumes the sequencer gates them into the drive; one clock domain
`timescale 1ns/1ps
`default_nettype none
module switch_model #(
   parameter int ON_CYC = 200,
   parameter int PERIOD = 300
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic pwm_on_o,
   output logic pwm_off_o
);
   int cnt;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      end
   end
   // on phase outlasts the current-sense sample point after turn-on
   assign pwm_on_o = (cnt < ON_CYC) && !rst_i;
   assign pwm_off_o = !pwm_on_o;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench of the protection sequencer
// assumes switch_model supplies the turn-on and turn-off requests
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import prot_seq_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pwm_on, pwm_off;
   logic brown_in = 1'b0, brown_out = 1'b0, start = 1'b0, maintain = 1'b0;
   logic fb_low = 1'b0, otp = 1'b0, fault_prev = 1'b0;
   logic [6:0] bad = 7'h00;
   logic gate_o, ctrl_source_o, charge_high_o, cmp_mask_o, fault_o;
   logic [6:0] fault_cause_o;
   logic [6:0] exp_q[$];
   int fails = 0, n_tests = 0, cyc = 0, k, hi_cnt = 0;
   integer seed = 32'hfeeb0ee0;
   always #12.5 clk_i = ~clk_i;
   switch_model pm (.clk_i(clk_i), .rst_i(rst_i), .pwm_on_o(pwm_on), .pwm_off_o(pwm_off));
   pwm_fault_protection_sequencer #(.BROWN_OUT_COUNT(200), .CTRL_LOW_COUNT(200),
      .UV_BLANK_COUNT(100), .SAMPLE_DELAY(40)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .pwm_on_i(pwm_on), .pwm_off_i(pwm_off), .line_brown_in_i(brown_in),
      .line_brown_out_i(brown_out), .line_ovp_i(bad[2]), .supply_start_i(start),
      .supply_maintain_i(maintain), .out_ovp_i(bad[6]), .out_uvp_i(bad[5]),
      .ctrl_high_i(bad[4]), .ctrl_low_i(bad[3]), .cs_fast_oc_i(bad[1]), .cs_short_i(bad[0]),
      .otp_trip_i(otp), .otp_release_i(!otp), .feedback_low_i(fb_low), .gate_o(gate_o),
      .ctrl_source_o(ctrl_source_o), .charge_high_o(charge_high_o), .charge_fault_o(),
      .cmp_mask_o(cmp_mask_o), .fault_o(fault_o), .fault_cause_o(fault_cause_o));
   task automatic check(input logic [6:0] seen, input logic [6:0] want);
      n_tests++;
      if (seen !== want) begin
         fails++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // waits, bounded, for the fault flag (f) or the gate to go high
   task automatic wait_on(input bit f);
      k = 0;
      while (((f ? fault_o : gate_o) !== 1'b1) && k < 5000) begin
         tick(1);
         k++;
      end
      @(negedge clk_i);
      check(f ? fault_o : gate_o, 1'b1);
      tick(1);
   endtask
   task automatic bring_up();
      {bad, brown_in, brown_out, start, fb_low, otp} <= '0;
      rst_i <= 1'b1;
      tick(6);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check({gate_o, fault_o, charge_high_o}, 3'b001);
      tick(1);
      {brown_in, start} <= 2'b11;
      tick(3900);
      @(negedge clk_i);
      check(gate_o, 1'b0);
      tick(1);
      wait_on(1'b0);
   endtask
   always @(posedge clk_i) begin
      maintain <= $random(seed);
   end
   always @(negedge clk_i) begin
      fault_prev <= fault_o;
      cyc <= cyc + 1;
      hi_cnt <= (gate_o === 1'b1) ? hi_cnt + 1 : 0;
      check(cmp_mask_o, (gate_o === 1'b1) && (hi_cnt < LEB_CYC));
      if (fault_o === 1'b1 && fault_prev !== 1'b1) begin
         if (exp_q.size() > 0) begin
            check(fault_cause_o, exp_q.pop_front());
         end else begin
            check(fault_o, 1'b0);
         end
      end
      if (cyc == 90000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      tick(1);
      for (int b = 0; b < 7; b++) begin
         bring_up();
         // five switching cycles of the condition then a clean gap
         if (b != 3) begin
            bad <= 7'h01 << b;
            tick(1500);
            bad <= 7'h00;
            tick(600);
            @(negedge clk_i);
            check(fault_o, 1'b0);
            tick(1);
         end
         exp_q.push_back(7'h01 << b);
         bad <= 7'h01 << b;
         wait_on(1'b1);
         tick(400);
         @(negedge clk_i);
         check({gate_o, ctrl_source_o, fault_o, charge_high_o}, 4'b0010);
         tick(1);
      end
      bring_up();
      {brown_in, brown_out} <= 2'b01;
      tick(260);
      @(negedge clk_i);
      check({gate_o, fault_o}, 2'b00);
      tick(1);
      {brown_in, brown_out} <= 2'b10;
      tick(3900);
      @(negedge clk_i);
      check(gate_o, 1'b0);
      tick(1);
      wait_on(1'b0);
      for (int s = 0; s < 2; s++) begin
         {fb_low, otp} <= s ? 2'b01 : 2'b10;
         tick(400);
         repeat (300) begin
            @(negedge clk_i);
            check(gate_o, 1'b0);
         end
         tick(1);
         {fb_low, otp} <= 2'b00;
         wait_on(1'b0);
      end
      final_report();
   end
endmodule
`default_nettype wire
